// file: hdl/mit_pkg.sv
// constants for the interrupt controller and time base
package mit_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00; // global, pin, tick and group enables
	localparam logic [7:0] OFS_EDGE  = 8'h04; // two edge bits per external pin
	localparam logic [7:0] OFS_FLAGS = 8'h08; // request flags, write one to clear
	localparam logic [7:0] OFS_TBC   = 8'h0C; // time_base_control
	localparam logic [7:0] OFS_GRP0  = 8'h10; // group 0 sources: timer 0 matches
	localparam logic [7:0] OFS_GRP1  = 8'h14; // group 1 sources: timer 1 matches
	localparam logic [7:0] OFS_GRP2  = 8'h18; // group 2 sources: low supply, eeprom
	localparam logic [7:0] OFS_STAT  = 8'h1C; // pin levels and pending request
	// control register fields
	localparam int CTRL_GIE   = 0; // global_irq_enable
	localparam int CTRL_EXT   = 1; // ext_pin_irq_enables, 2 bits
	localparam int CTRL_TICK  = 3; // tick_irq_enable 0 and 1
	localparam int CTRL_GRP   = 5; // group enables, 3 bits
	localparam int CTRL_PULL  = 8; // pin pull-high selects, 2 bits
	localparam int CTRL_W     = 10;
	// flag vector order, also the priority order, lowest index wins
	localparam int NVEC       = 7;
	localparam int FL_EXT     = 0; // ext_pin_req_flags 1:0
	localparam int FL_TICK    = 2; // tick_req_flag 1:0
	localparam int FL_GRP     = 4; // group_req_flags 2:0
	// edge select codes
	localparam logic [1:0] EDGE_OFF  = 2'h0; // pin function disabled
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// time_base_control fields
	localparam int TBC_ON     = 7; // tick_on
	localparam int TBC_CK     = 6; // tick_clock_select
	localparam int TBC_P1     = 4; // tick1_period_sel 5:4
	localparam int TBC_P0     = 0; // tick0_period_sel 2:0
	localparam logic [7:0] TBC_RST  = 8'h37;
	localparam logic [7:0] TBC_MASK = 8'hF7; // bit 3 reads zero
	localparam int TB0_BASE   = 8;  // tick 0 period 2^(8+code)
	localparam int TB1_BASE   = 12; // tick 1 period 2^(12+code)
	localparam int TB_CW      = 15; // divider counter width
	localparam logic [1:0] SYS_DIV_LAST = 2'h3; // system clock divide by four
	// group source register fields
	localparam int SRC_EN     = 0; // enables 1:0
	localparam int SRC_FL     = 4; // flags 5:4
	// axi responses
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : mit_pkg

// file: hdl/mit_irq_ctrl.sv
// interrupt controller with external pins, two time bases and three groups
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module mit_irq_ctrl (
	input  wire logic        clk,
	input  wire logic        rst,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// event sources
	input  wire logic [1:0]  ext_irq_pins,
	input  wire logic        sub_clk_tick,
	input  wire logic [1:0]  timer_match_p,
	input  wire logic [1:0]  timer_match_a,
	input  wire logic        eeprom_write_done,
	input  wire logic        low_supply_det,
	// core sequencer side
	input  wire logic        stack_full,
	input  wire logic        irq_ack,
	input  wire logic        return_from_irq_instr,
	output logic             irq_req,
	output logic [2:0]       irq_vector,
	output logic             wake,
	output logic [1:0]       pin_pullup_en
);
	// register state
	logic [mit_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;   // enables and pull-high
	logic [3:0]                 edge_q, edge_d;   // ext_edge_select_reg
	logic [mit_pkg::NVEC-1:0]   flags_q, flags_d; // vector request flags
	logic [7:0]                 tbc_q, tbc_d;     // time_base_control
	logic [5:0]                 sfl_q, sfl_d;     // source flags, 2 per group
	logic [5:0]                 sen_q, sen_d;     // source enables
	logic [1:0]                 pin_q, pin_d;     // previous pin levels
	logic [mit_pkg::TB_CW-1:0]  tbc_cnt_q, tbc_cnt_d; // time-base divider
	logic [1:0]                 div_q, div_d;     // system clock divide by four
	logic                       irq_req_q, irq_req_d;
	logic [2:0]                 vec_q, vec_d;
	logic                       wake_q, wake_d;
	logic [1:0]                 pull_q, pull_d;
	// axi state
	logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
	logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0]  aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        arr_q, arr_d, rv_q, rv_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	// true when the low n bits of the counter are all ones
	function automatic logic low_ones(input logic [mit_pkg::TB_CW-1:0] c, input int n);
		logic [mit_pkg::TB_CW-1:0] m;
		m = mit_pkg::TB_CW'((32'h1 << n) - 32'h1);
		return (c & m) == m;
	endfunction : low_ones

	// true when the edge selection matches the observed transition
	function automatic logic edge_hit(input logic [1:0] sel, input logic was, input logic now);
		logic rise;
		logic fall;
		rise = !was && now;
		fall = was && !now;
		case (sel)
			mit_pkg::EDGE_RISE: return rise;
			mit_pkg::EDGE_FALL: return fall;
			mit_pkg::EDGE_BOTH: return rise || fall;
			default:            return 1'b0; // off
		endcase
	endfunction : edge_hit

	// register read decode, used by the read channel
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			mit_pkg::OFS_CTRL:  r = 32'(ctrl_q);
			mit_pkg::OFS_EDGE:  r = 32'(edge_q);
			mit_pkg::OFS_FLAGS: r = 32'(flags_q);
			mit_pkg::OFS_TBC:   r = 32'(tbc_q & mit_pkg::TBC_MASK);
			mit_pkg::OFS_GRP0:  r = 32'({2'h0, sfl_q[1:0], 2'h0, sen_q[1:0]});
			mit_pkg::OFS_GRP1:  r = 32'({2'h0, sfl_q[3:2], 2'h0, sen_q[3:2]});
			mit_pkg::OFS_GRP2:  r = 32'({2'h0, sfl_q[5:4], 2'h0, sen_q[5:4]});
			mit_pkg::OFS_STAT:  r = 32'({vec_q, irq_req_q, 2'h0, pin_q});
			default:            r = 32'h0;
		endcase
		return r;
	endfunction : reg_read

	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= mit_pkg::OFS_STAT;
	endfunction : addr_ok

	// combinational signals
	logic       do_wr;       // write commits this cycle
	logic       tb_adv;      // time-base clock pulse
	logic       tb0_ovf, tb1_ovf;
	logic [5:0] src_evt;     // raw source events
	logic [5:0] sfl_set;     // source flags newly set and enabled
	logic [mit_pkg::NVEC-1:0] set_v, clr_sw, clr_hw, elig;
	logic [mit_pkg::NVEC-1:0] ven;

	// axi channel and register update
	always_comb
	begin
		aw_full_d = aw_full_q;
		w_full_d  = w_full_q;
		aw_addr_d = aw_addr_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bv_d      = bv_q;
		bresp_d   = bresp_q;
		rv_d      = rv_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		// address and data taken in either order
		if (s_axi_awvalid && awr_q)
		begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_q)
		begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		do_wr = aw_full_q && w_full_q && !bv_q;
		if (do_wr)
		begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bv_d      = 1'b1;
			bresp_d   = addr_ok(aw_addr_q) ? mit_pkg::RESP_OK : mit_pkg::RESP_ERR;
		end
		else if (bv_q && s_axi_bready)
		begin
			bv_d = 1'b0;
		end
		// read answers one cycle after address is taken
		if (s_axi_arvalid && arr_q)
		begin
			rv_d    = 1'b1;
			rdata_d = reg_read(s_axi_araddr);
			rresp_d = addr_ok(s_axi_araddr) ? mit_pkg::RESP_OK : mit_pkg::RESP_ERR;
		end
		else if (rv_q && s_axi_rready)
		begin
			rv_d = 1'b0;
		end
		awr_d = !aw_full_d && !bv_d;
		wr_d  = !w_full_d && !bv_d;
		arr_d = !rv_d;
	end

	// time base divider and edge detection
	always_comb
	begin
		div_d = div_q + 2'h1;
		// select source of the tick clock
		tb_adv = tbc_q[mit_pkg::TBC_CK] ? (div_q == mit_pkg::SYS_DIV_LAST) : sub_clk_tick;
		tb_adv = tb_adv && tbc_q[mit_pkg::TBC_ON];
		tbc_cnt_d = tbc_cnt_q;
		if (!tbc_q[mit_pkg::TBC_ON])
		begin
			tbc_cnt_d = '0; // stopped dividers restart from zero
		end
		else if (tb_adv)
		begin
			tbc_cnt_d = tbc_cnt_q + mit_pkg::TB_CW'(1);
		end
		// overflow at 2^(base+code) time-base clock pulses
		tb0_ovf = tb_adv && low_ones(tbc_cnt_q,
			mit_pkg::TB0_BASE + int'(tbc_q[mit_pkg::TBC_P0 +: 3]));
		tb1_ovf = tb_adv && low_ones(tbc_cnt_q,
			mit_pkg::TB1_BASE + int'(tbc_q[mit_pkg::TBC_P1 +: 2]));
		pin_d  = ext_irq_pins;
		pull_d = ctrl_q[mit_pkg::CTRL_PULL +: 2];
	end

	// flags, enables and request arbitration
	always_comb
	begin
		ctrl_d = ctrl_q;
		edge_d = edge_q;
		tbc_d  = tbc_q;
		sen_d  = sen_q;
		clr_sw = '0;
		sfl_d  = sfl_q;
		// source events: group 0 timer 0, group 1 timer 1, group 2 supply and eeprom
		src_evt = {eeprom_write_done, low_supply_det, timer_match_a[1], timer_match_p[1],
			timer_match_a[0], timer_match_p[0]};
		// software access: writes first so that hardware sets win below
		if (do_wr && w_strb_q[0])
		begin
			case (aw_addr_q)
				mit_pkg::OFS_CTRL:  ctrl_d = w_data_q[mit_pkg::CTRL_W-1:0];
				mit_pkg::OFS_EDGE:  edge_d = w_data_q[3:0];
				mit_pkg::OFS_FLAGS: clr_sw = w_data_q[mit_pkg::NVEC-1:0];
				mit_pkg::OFS_TBC:   tbc_d  = w_data_q[7:0] & mit_pkg::TBC_MASK;
				mit_pkg::OFS_GRP0:
				begin
					sen_d[1:0] = w_data_q[mit_pkg::SRC_EN +: 2];
					sfl_d[1:0] = sfl_q[1:0] & ~w_data_q[mit_pkg::SRC_FL +: 2];
				end
				mit_pkg::OFS_GRP1:
				begin
					sen_d[3:2] = w_data_q[mit_pkg::SRC_EN +: 2];
					sfl_d[3:2] = sfl_q[3:2] & ~w_data_q[mit_pkg::SRC_FL +: 2];
				end
				mit_pkg::OFS_GRP2:
				begin
					sen_d[5:4] = w_data_q[mit_pkg::SRC_EN +: 2];
					sfl_d[5:4] = sfl_q[5:4] & ~w_data_q[mit_pkg::SRC_FL +: 2];
				end
				default: ;
			endcase
		end
		if (do_wr && w_strb_q[1] && aw_addr_q == mit_pkg::OFS_CTRL)
		begin
			ctrl_d[mit_pkg::CTRL_W-1:8] = w_data_q[mit_pkg::CTRL_W-1:8];
		end
		// source flags set by events, set wins over clear
		sfl_d = sfl_d | src_evt;
		// group flag set when an enabled source flag becomes set
		sfl_set = sfl_d & ~sfl_q & sen_q;
		set_v = '0;
		set_v[mit_pkg::FL_EXT]     = edge_hit(edge_q[1:0], pin_q[0], ext_irq_pins[0]);
		set_v[mit_pkg::FL_EXT + 1] = edge_hit(edge_q[3:2], pin_q[1], ext_irq_pins[1]);
		set_v[mit_pkg::FL_TICK]     = tb0_ovf;
		set_v[mit_pkg::FL_TICK + 1] = tb1_ovf;
		set_v[mit_pkg::FL_GRP]      = |sfl_set[1:0];
		set_v[mit_pkg::FL_GRP + 1]  = |sfl_set[3:2];
		set_v[mit_pkg::FL_GRP + 2]  = |sfl_set[5:4];
		// per vector enables; pins also need an edge chosen
		ven = {ctrl_q[mit_pkg::CTRL_GRP +: 3], ctrl_q[mit_pkg::CTRL_TICK +: 2],
			ctrl_q[mit_pkg::CTRL_EXT + 1] && edge_q[3:2] != mit_pkg::EDGE_OFF,
			ctrl_q[mit_pkg::CTRL_EXT] && edge_q[1:0] != mit_pkg::EDGE_OFF};
		// service clears only the granted flag
		clr_hw = '0;
		if (irq_ack && irq_req_q)
		begin
			clr_hw[vec_q] = 1'b1;
		end
		flags_d = (flags_q & ~clr_sw & ~clr_hw) | set_v;
		// global enable: cleared on service, set again by return from irq
		if (irq_ack && irq_req_q)
		begin
			ctrl_d[mit_pkg::CTRL_GIE] = 1'b0;
		end
		else if (return_from_irq_instr)
		begin
			ctrl_d[mit_pkg::CTRL_GIE] = 1'b1;
		end
		// eligible requests, held off while stack is full
		elig = flags_d & ven;
		irq_req_d = |elig && ctrl_d[mit_pkg::CTRL_GIE] && !stack_full;
		vec_d = vec_q;
		// lowest index wins, others stay pending
		for (int i = mit_pkg::NVEC - 1; i >= 0; i--)
		begin
			if (elig[i])
			begin
				vec_d = 3'(i);
			end
		end
		wake_d = |(flags_d & ~flags_q);
	end

	// state registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_q    <= '0;
			edge_q    <= '0;
			flags_q   <= '0;
			tbc_q     <= mit_pkg::TBC_RST;
			sfl_q     <= '0;
			sen_q     <= '0;
			pin_q     <= '0;
			tbc_cnt_q <= '0;
			div_q     <= '0;
			irq_req_q <= 1'b0;
			vec_q     <= '0;
			wake_q    <= 1'b0;
			pull_q    <= '0;
			awr_q     <= 1'b0;
			wr_q      <= 1'b0;
			bv_q      <= 1'b0;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bresp_q   <= mit_pkg::RESP_OK;
			arr_q     <= 1'b0;
			rv_q      <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= mit_pkg::RESP_OK;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			edge_q    <= edge_d;
			flags_q   <= flags_d;
			tbc_q     <= tbc_d;
			sfl_q     <= sfl_d;
			sen_q     <= sen_d;
			pin_q     <= pin_d;
			tbc_cnt_q <= tbc_cnt_d;
			div_q     <= div_d;
			irq_req_q <= irq_req_d;
			vec_q     <= vec_d;
			wake_q    <= wake_d;
			pull_q    <= pull_d;
			awr_q     <= awr_d;
			wr_q      <= wr_d;
			bv_q      <= bv_d;
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			aw_addr_q <= aw_addr_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bresp_q   <= bresp_d;
			arr_q     <= arr_d;
			rv_q      <= rv_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awr_q;
	assign s_axi_wready  = wr_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign irq_req       = irq_req_q;
	assign irq_vector    = vec_q;
	assign wake          = wake_q;
	assign pin_pullup_en = pull_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_pin_rise_flag: assert property (
		edge_q[1:0] == mit_pkg::EDGE_RISE && !pin_q[0] && ext_irq_pins[0]
		|=> flags_q[mit_pkg::FL_EXT])
		else $error("rising pin edge did not set flag");
	chk_edge_off_quiet: assert property (
		edge_q[1:0] == mit_pkg::EDGE_OFF && !flags_q[mit_pkg::FL_EXT]
		|=> !flags_q[mit_pkg::FL_EXT])
		else $error("disabled pin still flagged");
	chk_stack_full_hold: assert property (
		stack_full |=> !irq_req_q)
		else $error("request raised while stack full");
	chk_service_clear: assert property (
		irq_ack && irq_req_q |=> !ctrl_q[mit_pkg::CTRL_GIE] ##0 !irq_req_q)
		else $error("service did not clear global enable");
	chk_no_req_noglobal: assert property (
		!ctrl_q[mit_pkg::CTRL_GIE] && !return_from_irq_instr
		&& !(do_wr && w_strb_q[0] && aw_addr_q == mit_pkg::OFS_CTRL) |=> !irq_req_q)
		else $error("request without global enable");
	chk_return_from_irq_instr_sets: assert property (
		return_from_irq_instr && !(irq_ack && irq_req_q) |=> ctrl_q[mit_pkg::CTRL_GIE])
		else $error("return did not restore global enable");
	chk_wake_rise: assert property (
		$rose(flags_q[mit_pkg::FL_TICK]) |-> wake_q)
		else $error("flag rise gave no wake");
	chk_tick_off_idle: assert property (
		!tbc_q[mit_pkg::TBC_ON] |=> tbc_cnt_q == '0 ##0 !$rose(flags_q[mit_pkg::FL_TICK]))
		else $error("time base ran while off");
	chk_tbc_bit3_zero: assert property (
		tbc_q[3] == 1'b0)
		else $error("time base control bit 3 set");
	chk_group_needs_en: assert property (
		$rose(flags_q[mit_pkg::FL_GRP + 2]) |-> $past(|sen_q[5:4]))
		else $error("group flag set by disabled source");
	chk_vec_priority: assert property (
		irq_req_q && flags_q[mit_pkg::FL_EXT] && $past(ven[mit_pkg::FL_EXT])
		&& $past(flags_q[mit_pkg::FL_EXT]) |-> vec_q == 3'h0)
		else $error("priority order broken");

	cov_pin_service: cover property (irq_req_q && vec_q == 3'h0 ##1 irq_ack);
	cov_tick_overflow: cover property ($rose(flags_q[mit_pkg::FL_TICK + 1]));
	cov_group_service: cover property (irq_ack && irq_req_q && vec_q == 3'h6);
	cov_return_from_irq_instr_nest: cover property (irq_ack && irq_req_q ##[1:20] return_from_irq_instr);
endmodule : mit_irq_ctrl

// file: verification/mit_seq_model.sv
// behavioural model of the core sequencer that takes the vectors
`timescale 1ns/1ps
module mit_seq_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       irq_req,
	input  wire logic [2:0] irq_vector,
	input  wire logic       full_cmd,
	input  wire logic [3:0] ack_wait,
	input  wire logic       auto_ret,
	output logic            stack_full,
	output logic            irq_ack,
	output logic            return_from_irq_instr
);
	int         wait_n = 0; // cycles the request has been seen
	int         ret_n  = 0; // cycles left until the return
	logic [2:0] served_q[$]; // vectors taken, oldest first

	// take a pending request after ack_wait cycles, return a little later
	always @(posedge clk)
	begin
		irq_ack <= 1'b0;
		return_from_irq_instr <= 1'b0;
		stack_full <= full_cmd;
		if (rst)
		begin
			wait_n = 0;
			ret_n = 0;
		end
		else if (irq_ack)
		begin
			// vector is valid at the acknowledge edge
			served_q.push_back(irq_vector);
			wait_n = 0;
			ret_n = auto_ret ? 4 : 0;
		end
		else if (ret_n > 0)
		begin
			ret_n--;
			if (ret_n == 0)
				return_from_irq_instr <= 1'b1;
		end
		else if (irq_req === 1'b1)
		begin
			wait_n++;
			if (wait_n > int'(ack_wait))
				irq_ack <= 1'b1;
		end
		else
			wait_n = 0;
	end
endmodule : mit_seq_model

// file: verification/mcu_interrupt_and_time_base_bench.sv
// self-checking bench for the interrupt controller and time base
`timescale 1ns/1ps
module mcu_interrupt_and_time_base_bench;
	logic        clk, rst;                       // system clock, reset
	logic [7:0]  awaddr, araddr;                 // register addresses
	logic [31:0] wdata, rdata, rd;               // bus data, read copy
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, rsp;
	logic [1:0]  pins, mp, ma, pull_en;          // pins, timer matches
	logic        sub_tick, ee_done, low_det;     // event sources
	logic        full_cmd, auto_ret, stack_full, irq_ack, ret_irq;
	logic [3:0]  ack_wait;                       // core answer delay
	logic        irq_req, wake;
	logic [2:0]  irq_vector;
	int          err_total = 0, comparisons = 0, cyc = 0, wake_cnt = 0;

	// free-running clock
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// cycle count, wake pulse count, subsystem tick every 8 cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		sub_tick <= (cyc % 8 == 6);
		if (wake === 1'b1)
			wake_cnt <= wake_cnt + 1;
	end

	mit_irq_ctrl dut (.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq_pins(pins),
		.sub_clk_tick(sub_tick), .timer_match_p(mp), .timer_match_a(ma),
		.eeprom_write_done(ee_done), .low_supply_det(low_det),
		.stack_full(stack_full), .irq_ack(irq_ack),
		.return_from_irq_instr(ret_irq), .irq_req(irq_req),
		.irq_vector(irq_vector), .wake(wake), .pin_pullup_en(pull_en));

	mit_seq_model core (.clk(clk), .rst(rst), .irq_req(irq_req),
		.irq_vector(irq_vector), .full_cmd(full_cmd), .ack_wait(ack_wait),
		.auto_ret(auto_ret), .stack_full(stack_full), .irq_ack(irq_ack),
		.return_from_irq_instr(ret_irq));

	// one comparison, counted
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// verdict and end of run
	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// a wait that ran out ends the run
	task automatic tmo(input int n, input int lim);
		if (n >= lim)
		begin
			err_total++;
			$display("Error wait expected answer seen none");
			results();
		end
	endtask : tmo

	// bus write, both channels offered together, response checked
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit ad;
		bit wd;
		n = 0;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			n++;
			if (ad && wd && bvalid === 1'b1)
				break;
			if (awready === 1'b1)
			begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				wd = 1;
				wvalid <= 1'b0;
			end
			tmo(n, 40);
		end
		chk("bresp", 32'(bresp), 32'(er));
	endtask : axi_wr

	// bus read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		bit ad;
		n = 0;
		ad = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clk);
			n++;
			if (ad && rvalid === 1'b1)
				break;
			if (arready === 1'b1)
			begin
				ad = 1;
				arvalid <= 1'b0;
			end
			tmo(n, 40);
		end
		d = rdata;
		r = rresp;
	endtask : axi_rd

	// read a register and compare with the model value
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, rd, rsp);
		chk(nm, rd, e);
	endtask : rdc

	// next vector taken by the core model
	task automatic served(input int e);
		int n;
		n = 0;
		while (core.served_q.size() == 0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		tmo(n, 200);
		chk("vector", 32'(core.served_q.pop_front()), 32'(e));
	endtask : served

	// restart the time base and time the flag at bit b
	task automatic tick_meas(input logic [7:0] time_base_control, input int b, input int per, input int tol);
		int t0;
		int n;
		axi_wr(mit_pkg::OFS_TBC, 32'h0, mit_pkg::RESP_OK);
		axi_wr(mit_pkg::OFS_FLAGS, 32'h7F, mit_pkg::RESP_OK);
		axi_wr(mit_pkg::OFS_TBC, 32'(time_base_control), mit_pkg::RESP_OK);
		t0 = cyc;
		rd = 32'h0;
		n = 0;
		while (rd[b] !== 1'b1 && n < 9000)
		begin
			axi_rd(mit_pkg::OFS_FLAGS, rd, rsp);
			n++;
		end
		tmo(n, 9000);
		chk("period", 32'(cyc - t0 > per - tol && cyc - t0 < per + tol), 32'h1);
	endtask : tick_meas

	// main sequence
	initial
	begin
		int base;
		int ew;
		int t;
		{rst, awaddr, araddr, wdata, wstrb} = {1'b1, 8'h0, 8'h0, 32'h0, 4'hF};
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{pins, mp, ma, ee_done, low_det, full_cmd} = 9'h0;
		auto_ret = 1'b1;
		ack_wait = 4'h0;
		t = $urandom(32'h70d0e135);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		ack_wait <= 4'($urandom_range(7, 0));
		t = $urandom_range(1, 0);
		@(posedge clk);
		// reset values, bit 3 reads zero, unmapped place
		rdc("tbc_rst", mit_pkg::OFS_TBC, 32'h37);
		axi_wr(mit_pkg::OFS_TBC, 32'h7F, mit_pkg::RESP_OK);
		rdc("tbc_bit3", mit_pkg::OFS_TBC, 32'h77);
		axi_wr(8'h20, 32'h1, mit_pkg::RESP_ERR);
		axi_rd(8'h24, rd, rsp);
		chk("bad_read", 32'(rsp), 32'(mit_pkg::RESP_ERR));
		// every edge code on both pins, global enable off
		base = wake_cnt;
		ew = 0;
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < 4; c++)
			begin
				axi_wr(mit_pkg::OFS_EDGE, 32'(c << (2 * p)), mit_pkg::RESP_OK);
				pins[p] <= 1'b1;
				repeat (5) @(posedge clk);
				ew += c & 1;
				rdc("rise", mit_pkg::OFS_FLAGS, 32'((c & 1) << p));
				axi_wr(mit_pkg::OFS_FLAGS, 32'h7F, mit_pkg::RESP_OK);
				pins[p] <= 1'b0;
				repeat (5) @(posedge clk);
				ew += c >> 1;
				rdc("fall", mit_pkg::OFS_FLAGS, 32'((c >> 1) << p));
				axi_wr(mit_pkg::OFS_FLAGS, 32'h7F, mit_pkg::RESP_OK);
			end
		chk("wake", 32'(wake_cnt - base), 32'(ew));
		// both pins at once behind a full stack, then released
		full_cmd <= 1'b1;
		axi_wr(mit_pkg::OFS_EDGE, 32'h5, mit_pkg::RESP_OK);
		axi_wr(mit_pkg::OFS_CTRL, 32'h307, mit_pkg::RESP_OK);
		@(posedge clk);
		chk("pullup", 32'(pull_en), 32'h3);
		pins <= 2'h3;
		repeat (10) @(posedge clk);
		chk("held", 32'(core.served_q.size()), 32'h0);
		rdc("pending", mit_pkg::OFS_FLAGS, 32'h3);
		full_cmd <= 1'b0;
		served(0);
		served(1);
		rdc("pin_clr", mit_pkg::OFS_FLAGS, 32'h0);
		repeat (8) @(posedge clk);
		rdc("return_from_irq_instr", mit_pkg::OFS_CTRL, 32'h307);
		// time base periods and clock selects, requests not enabled
		pins <= 2'h0;
		axi_wr(mit_pkg::OFS_CTRL, 32'h0, mit_pkg::RESP_OK);
		tick_meas(8'hC0, 2, 1024, 8);
		tick_meas(8'hC2, 2, 4096, 8);
		tick_meas(8'h80, 2, 2048, 16);
		tick_meas(8'hC0, 3, 16384, 8);
		axi_wr(mit_pkg::OFS_TBC, 32'h40, mit_pkg::RESP_OK);
		axi_wr(mit_pkg::OFS_FLAGS, 32'h7F, mit_pkg::RESP_OK);
		repeat (1100) @(posedge clk);
		rdc("tb_off", mit_pkg::OFS_FLAGS, 32'h0);
		// tick 0 service without return
		axi_wr(mit_pkg::OFS_TBC, 32'hC0, mit_pkg::RESP_OK);
		repeat (1100) @(posedge clk);
		axi_wr(mit_pkg::OFS_TBC, 32'h40, mit_pkg::RESP_OK);
		auto_ret <= 1'b0;
		axi_wr(mit_pkg::OFS_CTRL, 32'h9, mit_pkg::RESP_OK);
		served(2);
		rdc("gie_clr", mit_pkg::OFS_CTRL, 32'h8);
		rdc("tick_clr", mit_pkg::OFS_FLAGS, 32'h0);
		// groups: eeprom, low supply and one timer chosen at random
		auto_ret <= 1'b1;
		axi_wr(mit_pkg::OFS_CTRL, 32'h81 | (32'h20 << t), mit_pkg::RESP_OK);
		axi_wr(mit_pkg::OFS_GRP2, 32'h3, mit_pkg::RESP_OK);
		axi_wr(mit_pkg::OFS_GRP0 + 8'(4 * t), 32'h1, mit_pkg::RESP_OK);
		ee_done <= 1'b1;
		@(posedge clk);
		ee_done <= 1'b0;
		served(6);
		rdc("ee_src", mit_pkg::OFS_GRP2, 32'h23);
		axi_wr(mit_pkg::OFS_GRP2, 32'h33, mit_pkg::RESP_OK);
		rdc("src_clr", mit_pkg::OFS_GRP2, 32'h3);
		low_det <= 1'b1;
		@(posedge clk);
		low_det <= 1'b0;
		served(6);
		ma[t] <= 1'b1;
		@(posedge clk);
		ma[t] <= 1'b0;
		repeat (10) @(posedge clk);
		chk("a_masked", 32'(core.served_q.size()), 32'h0);
		rdc("a_flag", mit_pkg::OFS_GRP0 + 8'(4 * t), 32'h21);
		mp[t] <= 1'b1;
		@(posedge clk);
		mp[t] <= 1'b0;
		served(4 + t);
		rdc("grp_clr", mit_pkg::OFS_FLAGS, 32'h0);
		results();
	end
endmodule : mcu_interrupt_and_time_base_bench
